//--- dv/lcc_power_model.sv
module lcc_power_model (
    // switch fitting and pin control
    input wire logic fitted,
    input wire logic probe,
    input wire logic oe_n,
    input wire logic drv,
    // pin level seen by the block
    output logic sense
);
    timeunit 1ns;
    timeprecision 1ns;
    // grounded pin never reaches the probe level
    assign sense = !oe_n ? drv : (probe & fitted);
endmodule // lcc_power_model

//--- dv/test_li_ion_charge_state_controller.sv
module test_li_ion_charge_state_controller
    import lcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr, rd;
    logic [13:0] cmp = 14'h0;
    logic tmo = 1'b0;
    logic wake = 1'b0;
    logic fit = 1'b0;
    logic ack, g_in, g_out, g_oe_n, probe, buck, cv, wrun, wsel;
    logic [4:0] cur;
    logic [5:0] vol;
    logic [2:0] ecur, wcur;
    lcc_lin_t lin;
    lcc_loop_t lp;
    int n_errors = 0;
    int check_count = 0;
    always #25 core_clk = ~core_clk;
    lcc_charge_ctrl i_lcc_charge_ctrl (.core_clk(core_clk), .srst(srst), .wb_cyc(cyc),
        .wb_stb(cyc), .wb_we(we), .wb_adr(adr), .wb_sel(4'h1), .wb_dat_w(dw), .wb_dat_r(dr),
        .wb_ack(ack), .vin_detect(cmp[0]), .charger_detect(cmp[1]), .vbat_above_safe(cmp[2]),
        .vbat_above_pre(cmp[3]), .vbat_near_max(cmp[4]), .vbat_above_recharge(cmp[5]),
        .charge_current_low(cmp[6]), .vbat_above_weak(cmp[7]), .vsense_below_recharge(cmp[8]),
        .system_power_mode(cmp[9]), .input_limit_raised(cmp[10]), .hit_input_limit(cmp[11]),
        .hit_current_limit(cmp[12]), .hit_voltage_limit(cmp[13]), .safety_timeout(tmo),
        .wake_timer_expired(wake), .battery_switch_gate_in(g_in),
        .battery_switch_gate_out(g_out), .battery_switch_gate_oe_n(g_oe_n),
        .gate_probe_enable(probe), .buck_enable(buck), .cv_mode(cv), .current_setpoint(cur),
        .voltage_setpoint(vol), .end_current_setpoint(ecur), .weak_current_setpoint(wcur),
        .weak_threshold_select(wsel), .linear_source(lin), .active_loop(lp),
        .wake_timer_run(wrun));
    lcc_power_model i_lcc_power_model (.fitted(fit), .probe(probe), .oe_n(g_oe_n),
        .drv(g_out), .sense(g_in));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge core_clk);
        rd = dr;
        cyc <= 1'b0;
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
    endtask
    task automatic wait_st(input logic [3:0] s);
        int i;
        for (i = 0; i < 60; i++) begin
            bus(1'b0, OFS_STATUS, 32'h0);
            if (rd[3:0] === s) break;
        end
        chk(rd[3:0], s);
        if (rd[3:0] !== s) print_verdict();
    endtask
    task automatic set(input logic [13:0] v);
        @(posedge core_clk);
        cmp <= v;
        repeat (8) @(posedge core_clk);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(rd, 32'h1);
        chk({g_out, g_oe_n, probe, buck}, 4'h0);
        bus(1'b1, OFS_BATT_CURRENT, 32'hba);
        bus(1'b1, OFS_CHARGE_VOLTAGE, 32'h2b);
        chk(cur, 5'h1a);
        chk(ecur, 3'h5);
        chk(vol, 6'h2b);
        bus(1'b1, OFS_MISC_SETTING, 32'hf);
        chk({wcur, wsel}, 4'hf);
        bus(1'b0, 5'h18, 32'h0);
        chk(rd, 32'h0);
        set(14'h0001);
        wait_st(4'h0);
        set(14'h108f);
        wait_st(4'h5);
        chk(rd[4], 1'b0);
        chk({buck, g_out, lp}, {2'b10, LOOP_CURRENT});
        set(14'h109f);
        chk(cv, 1'b1);
        set(14'h10ff);
        wait_st(4'h6);
        set(14'h10df);
        wait_st(4'h5);
        $display("test run done");
        bus(1'b1, OFS_CONTROL_ONE, 32'h0);
        wait_st(4'ha);
        bus(1'b1, OFS_CONTROL_ONE, 32'h1);
        wait_st(4'h5);
        tmo <= 1'b1;
        wait_st(4'ha);
        tmo <= 1'b0;
        $display("test halt done");
        fit <= 1'b1;
        set(14'h0003);
        bus(1'b1, OFS_CONTROL_ONE, 32'h3);
        wait_st(4'h8);
        chk(rd[4], 1'b1);
        chk({g_out, lin, wrun}, {1'b1, LIN_SAFE, 1'b1});
        bus(1'b0, OFS_BATT_CURRENT, 32'h0);
        chk(rd, 32'h0);
        chk({wcur, wsel}, 4'h0);
        set(14'h0007);
        wait_st(4'h9);
        chk({g_out, lin, wrun}, {1'b1, LIN_WEAK, 1'b0});
        set(14'h0203);
        set(14'h0003);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd[3:0], 4'h9);
        set(14'h0203);
        wait_st(4'h3);
        chk({buck, lin}, {1'b1, LIN_SAFE});
        set(14'h0003);
        bus(1'b1, OFS_CONTROL_ONE, 32'h3);
        wait_st(4'h8);
        wake <= 1'b1;
        wait_st(4'h3);
        wake <= 1'b0;
        $display("test weak done");
        bus(1'b1, OFS_CONTROL_TWO, 32'h1);
        set(14'h10ff);
        wait_st(4'h6);
        chk({buck, g_out}, 2'b11);
        set(14'h11ff);
        chk(g_out, 1'b0);
        set(14'h10ff);
        chk(g_out, 1'b1);
        $display("test path done");
        print_verdict();
    end
endmodule // test_li_ion_charge_state_controller

//--- hdl/lcc_charge_ctrl.sv
// Functional notes
// RL1 - safe charge applies safe current until battery reaches safe threshold, then pre-charge
// RL2 - full charge current phase keeps buck enabled at programmed charge current
// RL3 - current setpoint is four-bit code plus high-range bit from one register
// RL4 - near maximum voltage, stay in full charge but regulate voltage by six-bit code
// RL5 - above recharge threshold and current below end level, enter end of charge
// RL6 - from end of charge, battery below recharge threshold returns to current phase
// RL7 - duty cycle follows whichever of three limits reaches its threshold first
// RL8 - leave off only with input detected and input-battery difference detected
// RL9 - after power-up record switch presence in status, then start charging automatically
// RL10 - charge-allow bit zero sends the controller to fault from any state; the code does so only outside off and while plugged
// RL11 - register clear restores all defaults and retriggers switch detection
// RL12 - switch gate low normally and always above weak threshold, except listed states
// RL13 - config state probes gate pin; reaching threshold means a switch is present
// RL14 - detection result held for the cycle, redone only on unplug or register clear
// RL15 - wait goes to weak wait with switch present, below weak, power mode zero
// RL16 - weak wait: buck at charge voltage, switch open, linear source off
// RL17 - weak safe: linear safe current, buck at charge voltage, switch open
// RL18 - weak safe: wake timeout without raised limit goes safe, else weak charge
// RL19 - weak charge: linear weak current, buck at charge voltage, wake timer stopped
// RL20 - weak charge above weak threshold moves to full charge and closes switch
// RL21 - third power mode toggle in weak states jumps to safe charge
// RL22 - path management opens switch in end of charge while buck supplies system
// RL23 - system sense below recharge recloses switch until end conditions met again
// RL24 - any safety timer expiry halts charging
// RL25 - every comparator input is synchronised before use in transitions
// RL26 - toggle counter clears on leaving weak states short of three toggles
module lcc_charge_ctrl
    import lcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [4:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // analog comparators, asynchronous
    input wire logic vin_detect,
    input wire logic charger_detect,
    input wire logic vbat_above_safe,
    input wire logic vbat_above_pre,
    input wire logic vbat_near_max,
    input wire logic vbat_above_recharge,
    input wire logic charge_current_low,
    input wire logic vbat_above_weak,
    input wire logic vsense_below_recharge,
    input wire logic system_power_mode,
    input wire logic input_limit_raised,
    input wire logic hit_input_limit,
    input wire logic hit_current_limit,
    input wire logic hit_voltage_limit,
    // timers, core clock domain
    input wire logic safety_timeout,
    input wire logic wake_timer_expired,
    // battery switch gate pin
    input wire logic battery_switch_gate_in,
    output logic battery_switch_gate_out,
    output logic battery_switch_gate_oe_n,
    output logic gate_probe_enable,
    // power stage
    output logic buck_enable,
    output logic cv_mode,
    output logic [4:0] current_setpoint,
    output logic [5:0] voltage_setpoint,
    output logic [2:0] end_current_setpoint,
    output logic [2:0] weak_current_setpoint,
    output logic weak_threshold_select,
    output lcc_lin_t linear_source,
    output lcc_loop_t active_loop,
    output logic wake_timer_run
);
    lcc_sync_if sif ();

    logic [NUM_IN-1:0] c;
    logic ack_q, ack_d, allow_q, allow_d, path_q, path_d, redetect_q, redetect_d;
    logic [31:0] dat_q, dat_d;
    lcc_batt_set_t batt_q, batt_d;
    logic [VCHG_W-1:0] vchg_q, vchg_d;
    lcc_misc_t misc_q, misc_d;
    lcc_state_t state_q, state_d;
    logic [4:0] cfg_cnt_q, cfg_cnt_d;
    logic present_q, present_d, spm_prev_q, spm_prev_d, reconnect_q, reconnect_d;
    logic [1:0] spm_cnt_q, spm_cnt_d;
    logic buck_q, buck_d, cv_q, cv_d, gate_open_q, gate_open_d, probe_q, probe_d;
    lcc_lin_t lin_q, lin_d;
    lcc_loop_t loop_q, loop_d;
    logic plugged, run_ok, weak_st, weak_st_d, spm_edge;

    function automatic logic eoc_met(input logic [NUM_IN-1:0] v);
        return v[IN_VBAT_RECHG] && v[IN_CHARGE_CURRENT_CODE_LOW];
    endfunction

    function automatic logic is_weak(input lcc_state_t s);
        return (s == ST_WEAK_WAIT) || (s == ST_WEAK_SAFE) || (s == ST_WEAK_CHARGE);
    endfunction

    // comparator synchronisers
    assign sif.raw = {hit_voltage_limit, hit_current_limit, hit_input_limit,
                      battery_switch_gate_in, input_limit_raised, system_power_mode,
                      vsense_below_recharge, vbat_above_weak, charge_current_low,
                      vbat_above_recharge, vbat_near_max, vbat_above_pre,
                      vbat_above_safe, charger_detect, vin_detect};

    // RL25 synchronise comparator inputs
    lcc_sync u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .port(sif.sync)
    );
    assign c = sif.clean;

    // register bus group
    always_comb begin
        ack_d = wb_cyc && wb_stb && !ack_q;
        dat_d = '0;
        allow_d = allow_q;
        path_d = path_q;
        batt_d = batt_q;
        vchg_d = vchg_q;
        misc_d = misc_q;
        redetect_d = 1'b0;
        if (ack_d && !wb_we) begin
            case (wb_adr)
                OFS_CONTROL_ONE: dat_d[CONTROL_REG_ONE_ALLOW_BIT] = allow_q;
                OFS_CONTROL_TWO: dat_d[CONTROL_REG_TWO_PATH_BIT] = path_q;
                OFS_BATT_CURRENT: dat_d[$bits(lcc_batt_set_t)-1:0] = batt_q;
                OFS_CHARGE_VOLTAGE: dat_d[VCHG_W-1:0] = vchg_q;
                OFS_MISC_SETTING: dat_d[$bits(lcc_misc_t)-1:0] = misc_q;
                // RL9 switch presence reported
                OFS_STATUS: dat_d[$bits(lcc_state_t)+4-1:0] = {loop_q, cv_q, present_q, state_q};
                default: dat_d = '0;
            endcase
        end
        if (ack_d && wb_we && wb_sel[0]) begin
            case (wb_adr)
                OFS_CONTROL_ONE: begin
                    // RL11 register clear restores defaults
                    if (wb_dat_w[CONTROL_REG_ONE_CLEAR_BIT]) begin
                        allow_d = ALLOW_RST;
                        path_d = PATH_RST;
                        batt_d = BATT_RST;
                        vchg_d = VCHG_RST;
                        misc_d = MISC_RST;
                        redetect_d = 1'b1;
                    end else begin
                        allow_d = wb_dat_w[CONTROL_REG_ONE_ALLOW_BIT];
                    end
                end
                OFS_CONTROL_TWO: path_d = wb_dat_w[CONTROL_REG_TWO_PATH_BIT];
                OFS_BATT_CURRENT: batt_d = lcc_batt_set_t'(wb_dat_w[$bits(lcc_batt_set_t)-1:0]);
                OFS_CHARGE_VOLTAGE: vchg_d = wb_dat_w[VCHG_W-1:0];
                OFS_MISC_SETTING: misc_d = lcc_misc_t'(wb_dat_w[$bits(lcc_misc_t)-1:0]);
                default: path_d = path_q;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
            allow_q <= ALLOW_RST;
            path_q <= PATH_RST;
            batt_q <= BATT_RST;
            vchg_q <= VCHG_RST;
            misc_q <= MISC_RST;
            redetect_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            allow_q <= allow_d;
            path_q <= path_d;
            batt_q <= batt_d;
            vchg_q <= vchg_d;
            misc_q <= misc_d;
            redetect_q <= redetect_d;
        end
    end

    // charge state group
    assign plugged = c[IN_VIN_DET] && c[IN_CHG_DET];
    assign run_ok = plugged && allow_q && !safety_timeout && !redetect_q;
    assign weak_st = is_weak(state_q);
    assign spm_edge = c[IN_SPM] != spm_prev_q;

    always_comb begin
        state_d = state_q;
        cfg_cnt_d = '0;
        present_d = present_q;
        reconnect_d = reconnect_q;
        spm_prev_d = c[IN_SPM];
        spm_cnt_d = spm_cnt_q;
        if (!plugged) begin
            // unplug ends the cycle; detection is redone on the next plug
            state_d = ST_OFF;
        end else if (state_q != ST_OFF && (!allow_q || safety_timeout)) begin
            // RL10 charge-allow cleared
            // RL24 safety timer halts charging
            state_d = ST_FAULT;
        end else if (redetect_q && state_q != ST_OFF) begin
            // RL14 detection redone after register clear
            state_d = ST_CONFIG;
        end else begin
            unique case (state_q)
                // RL8 plug detection
                ST_OFF: if (plugged) state_d = ST_CONFIG;
                ST_CONFIG: begin
                    cfg_cnt_d = cfg_cnt_q + 5'h01;
                    if (cfg_cnt_q == CONFIG_LAST) begin
                        // RL13 probe result latched
                        present_d = c[IN_GATE_DET];
                        // RL9 automatic start
                        state_d = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // RL15 weak battery entry
                    if (present_q && !c[IN_VBAT_WEAK] && !c[IN_SPM]) state_d = ST_WEAK_WAIT;
                    else if (!c[IN_VBAT_SAFE]) state_d = ST_SAFE;
                    else if (!c[IN_VBAT_PRE]) state_d = ST_PRE;
                    else state_d = ST_FULL;
                end
                // RL1 safe to pre-charge
                ST_SAFE: if (c[IN_VBAT_SAFE]) state_d = ST_PRE;
                ST_PRE: if (c[IN_VBAT_PRE]) state_d = ST_FULL;
                ST_FULL: begin
                    // RL5 end of charge entry
                    if (eoc_met(c)) begin
                        state_d = ST_EOC;
                        reconnect_d = 1'b0;
                    end
                end
                ST_EOC: begin
                    // RL6 recharge
                    if (!c[IN_VBAT_RECHG]) state_d = ST_FULL;
                    // RL23 reconnect on system droop
                    if (c[IN_VSENSE_LOW]) reconnect_d = 1'b1;
                    else if (eoc_met(c)) reconnect_d = 1'b0;
                end
                ST_WEAK_WAIT: state_d = c[IN_VBAT_SAFE] ? ST_WEAK_CHARGE : ST_WEAK_SAFE;
                ST_WEAK_SAFE: begin
                    // RL18 wake timeout or weak charge
                    if (wake_timer_expired && !c[IN_ILIM_RAISED]) state_d = ST_SAFE;
                    else if (c[IN_VBAT_SAFE]) state_d = ST_WEAK_CHARGE;
                end
                // RL20 weak charge done
                ST_WEAK_CHARGE: if (c[IN_VBAT_WEAK]) state_d = ST_FULL;
                ST_FAULT: state_d = ST_WAIT;
            endcase
            // RL21 third toggle aborts weak charging
            if (weak_st && spm_edge && spm_cnt_q == SPM_TOGGLE_LAST) state_d = ST_SAFE;
        end
        if (state_d == ST_OFF || state_d == ST_CONFIG) present_d = 1'b0;
        // RL26 toggle count cleared outside weak states
        if (!is_weak(state_d)) spm_cnt_d = '0;
        else if (weak_st && spm_edge) spm_cnt_d = spm_cnt_q + 2'h1;
    end

    // outputs follow the next state so they line up with state_q
    always_comb begin
        weak_st_d = is_weak(state_d);
        buck_d = 1'b0;
        lin_d = LIN_OFF;
        cv_d = 1'b0;
        probe_d = state_d == ST_CONFIG;
        unique case (state_d)
            ST_SAFE: begin
                buck_d = 1'b1;
                lin_d = LIN_SAFE;
            end
            ST_PRE: begin
                buck_d = 1'b1;
                lin_d = LIN_PRE;
            end
            ST_FULL: begin
                // RL2 buck runs at charge current
                buck_d = 1'b1;
                // RL4 constant voltage near maximum
                cv_d = c[IN_VBAT_NEAR];
            end
            // RL22 buck keeps supplying system
            ST_EOC: buck_d = path_q && present_q;
            // RL16 weak wait, linear off
            ST_WEAK_WAIT: buck_d = 1'b1;
            ST_WEAK_SAFE: begin
                // RL17 linear safe current
                buck_d = 1'b1;
                lin_d = LIN_SAFE;
            end
            ST_WEAK_CHARGE: begin
                // RL19 linear weak current
                buck_d = 1'b1;
                lin_d = LIN_WEAK;
            end
            default: buck_d = 1'b0;
        endcase
        // RL12 open only in weak or path states
        gate_open_d = (weak_st_d && !c[IN_VBAT_WEAK])
            || (state_d == ST_EOC && path_q && present_q && !reconnect_d);
        // RL7 first loop to reach its limit keeps control
        loop_d = LOOP_NONE;
        if (buck_d) begin
            if (loop_q == LOOP_INPUT && c[IN_HIT_INPUT]) loop_d = LOOP_INPUT;
            else if (loop_q == LOOP_CURRENT && c[IN_HIT_CURRENT]) loop_d = LOOP_CURRENT;
            else if (loop_q == LOOP_VOLTAGE && c[IN_HIT_VOLTAGE]) loop_d = LOOP_VOLTAGE;
            else if (c[IN_HIT_INPUT]) loop_d = LOOP_INPUT;
            else if (c[IN_HIT_CURRENT]) loop_d = LOOP_CURRENT;
            else if (c[IN_HIT_VOLTAGE]) loop_d = LOOP_VOLTAGE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_OFF;
            cfg_cnt_q <= '0;
            present_q <= 1'b0;
            reconnect_q <= 1'b0;
            spm_prev_q <= 1'b0;
            spm_cnt_q <= '0;
            buck_q <= 1'b0;
            lin_q <= LIN_OFF;
            cv_q <= 1'b0;
            gate_open_q <= 1'b0;
            probe_q <= 1'b0;
            loop_q <= LOOP_NONE;
        end else begin
            state_q <= state_d;
            cfg_cnt_q <= cfg_cnt_d;
            present_q <= present_d;
            reconnect_q <= reconnect_d;
            spm_prev_q <= spm_prev_d;
            spm_cnt_q <= spm_cnt_d;
            buck_q <= buck_d;
            lin_q <= lin_d;
            cv_q <= cv_d;
            gate_open_q <= gate_open_d;
            probe_q <= probe_d;
            loop_q <= loop_d;
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_q;
    // RL3 current setpoint from code and range bit
    assign current_setpoint = {batt_q.charge_current_high_range, batt_q.charge_current_code};
    assign voltage_setpoint = vchg_q;
    assign end_current_setpoint = batt_q.end_current_code;
    assign weak_current_setpoint = misc_q.weak_current_code;
    assign weak_threshold_select = misc_q.weak_threshold_select;
    assign buck_enable = buck_q;
    assign cv_mode = cv_q;
    assign linear_source = lin_q;
    assign active_loop = loop_q;
    // the probe releases the pin and lets a weak pull-up try to lift it
    assign battery_switch_gate_out = gate_open_q;
    assign battery_switch_gate_oe_n = probe_q;
    assign gate_probe_enable = probe_q;
    assign wake_timer_run = (state_q == ST_WEAK_WAIT) || (state_q == ST_WEAK_SAFE);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_OFF_HOLD: assert property ( // RL8
        state_q == ST_OFF && !(c[IN_VIN_DET] && c[IN_CHG_DET]) |=> state_q == ST_OFF)
        else $error("left off without plug detection");
    AST_ALLOW_FAULT: assert property ( // RL10
        state_q != ST_OFF && plugged && !allow_q |=> state_q == ST_FAULT)
        else $error("charge allow low did not give fault");
    AST_TIMEOUT_FAULT: assert property ( // RL24
        state_q != ST_OFF && plugged && safety_timeout |=> state_q == ST_FAULT && !buck_enable)
        else $error("safety timeout did not halt charge");
    AST_CC_OUTPUT: assert property ( // RL2
        state_q == ST_FULL |-> buck_enable && linear_source == LIN_OFF
            && current_setpoint == batt_q[$bits(current_setpoint)-1:0])
        else $error("full charge outputs wrong");
    AST_EOC_ENTRY: assert property ( // RL5
        state_q == ST_FULL && run_ok && eoc_met(c) |=> state_q == ST_EOC)
        else $error("end of charge not entered");
    AST_RECHARGE: assert property ( // RL6
        state_q == ST_EOC && run_ok && !c[IN_VBAT_RECHG] |=> state_q == ST_FULL)
        else $error("recharge not started");
    AST_GATE_LOW: assert property ( // RL12
        gate_open_q && state_q != ST_EOC |-> is_weak(state_q) && !$past(c[IN_VBAT_WEAK]))
        else $error("switch open above weak threshold");
    AST_DETECT: assert property ( // RL13
        state_q == ST_CONFIG && run_ok && cfg_cnt_q == CONFIG_LAST
            |=> state_q == ST_WAIT && present_q == $past(c[IN_GATE_DET]))
        else $error("switch detection not recorded");
    AST_SPM_THIRD: assert property ( // RL21
        weak_st && run_ok && spm_edge && spm_cnt_q == SPM_TOGGLE_LAST |=> state_q == ST_SAFE)
        else $error("third toggle ignored");
    AST_RECONNECT: assert property ( // RL23
        state_q == ST_EOC && c[IN_VSENSE_LOW] |=> !gate_open_q)
        else $error("switch not reclosed on droop");
    AST_REG_CLEAR: assert property ( // RL11
        ack_d && wb_we && wb_sel[0] && wb_adr == OFS_CONTROL_ONE && wb_dat_w[CONTROL_REG_ONE_CLEAR_BIT]
            |=> batt_q == BATT_RST && vchg_q == VCHG_RST && redetect_q)
        else $error("register clear incomplete");

    COV_EOC: cover property (state_q == ST_FULL ##1 state_q == ST_EOC);
    COV_WEAK_FULL: cover property (state_q == ST_WEAK_CHARGE ##1 state_q == ST_FULL);
    COV_SPM_ABORT: cover property (weak_st ##1 state_q == ST_SAFE);
    COV_PATH_OPEN: cover property (state_q == ST_EOC && gate_open_q);
endmodule // lcc_charge_ctrl

//--- hdl/lcc_sync.sv
module lcc_sync
    import lcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // comparator levels
    lcc_sync_if.sync port
);
    logic [NUM_IN-1:0] s1_q, s2_q, s3_q, clean_q;
    logic [NUM_IN-1:0] s1_d, s2_d, s3_d, clean_d;

    always_comb begin
        s1_d = port.raw;
        s2_d = s1_q;
        s3_d = s2_q;
        // a change is taken only once stages two and three agree
        clean_d = (s2_q & ~(s2_q ^ s3_q)) | (clean_q & (s2_q ^ s3_q));
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            clean_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            clean_q <= clean_d;
        end
    end

    assign port.clean = clean_q;
endmodule // lcc_sync

//--- shared/lcc_pkg.sv
package lcc_pkg;
    // timing at the 20 MHz core clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONFIG_TIME_NS = 1000;
    localparam int CONFIG_CYCLES = (CONFIG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] CONFIG_LAST = 5'(CONFIG_CYCLES - 1);

    // wishbone register byte offsets
    localparam logic [4:0] OFS_CONTROL_ONE = 5'h00;
    localparam logic [4:0] OFS_CONTROL_TWO = 5'h04;
    localparam logic [4:0] OFS_BATT_CURRENT = 5'h08;
    localparam logic [4:0] OFS_CHARGE_VOLTAGE = 5'h0c;
    localparam logic [4:0] OFS_MISC_SETTING = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;

    // control bit positions
    localparam int CONTROL_REG_ONE_ALLOW_BIT = 0;
    localparam int CONTROL_REG_ONE_CLEAR_BIT = 1;
    localparam int CONTROL_REG_TWO_PATH_BIT = 0;
    localparam int VCHG_W = 6;

    typedef struct packed {
        logic [2:0] end_current_code;
        logic charge_current_high_range;
        logic [3:0] charge_current_code;
    } lcc_batt_set_t;

    typedef struct packed {
        logic [2:0] weak_current_code;
        logic weak_threshold_select;
    } lcc_misc_t;

    // reset values
    localparam logic ALLOW_RST = 1'h1;
    localparam logic PATH_RST = 1'h0;
    localparam lcc_batt_set_t BATT_RST = 8'h00;
    localparam logic [5:0] VCHG_RST = 6'h00;
    localparam lcc_misc_t MISC_RST = 4'h0;

    // synchronised comparator inputs
    localparam int IN_VIN_DET = 0;
    localparam int IN_CHG_DET = 1;
    localparam int IN_VBAT_SAFE = 2;
    localparam int IN_VBAT_PRE = 3;
    localparam int IN_VBAT_NEAR = 4;
    localparam int IN_VBAT_RECHG = 5;
    localparam int IN_CHARGE_CURRENT_CODE_LOW = 6;
    localparam int IN_VBAT_WEAK = 7;
    localparam int IN_VSENSE_LOW = 8;
    localparam int IN_SPM = 9;
    localparam int IN_ILIM_RAISED = 10;
    localparam int IN_GATE_DET = 11;
    localparam int IN_HIT_INPUT = 12;
    localparam int IN_HIT_CURRENT = 13;
    localparam int IN_HIT_VOLTAGE = 14;
    localparam int NUM_IN = 15;

    localparam logic [1:0] SPM_TOGGLE_LAST = 2'h2;

    typedef enum logic [3:0] {
        ST_OFF, ST_CONFIG, ST_WAIT, ST_SAFE, ST_PRE, ST_FULL, ST_EOC,
        ST_WEAK_WAIT, ST_WEAK_SAFE, ST_WEAK_CHARGE, ST_FAULT
    } lcc_state_t;

    typedef enum logic [1:0] {LOOP_NONE, LOOP_INPUT, LOOP_CURRENT, LOOP_VOLTAGE} lcc_loop_t;
    typedef enum logic [1:0] {LIN_OFF, LIN_SAFE, LIN_PRE, LIN_WEAK} lcc_lin_t;
endpackage

//--- shared/lcc_sync_if.sv
interface lcc_sync_if;
    import lcc_pkg::*;
    logic [NUM_IN-1:0] raw;
    logic [NUM_IN-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
